//--- sar_adc_consts.svh
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_MUX 8'h04
`define OFS_RESULT 8'h08
`define OFS_WIN_LOW 8'h0C
`define OFS_WIN_HIGH 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18

// control register fields
`define CTRL_EN_BIT 0
`define CTRL_SWSTART_BIT 1
`define CTRL_TRIG_LSB 2
`define CTRL_TRIG_MSB 4
`define CTRL_WINOUT_BIT 5
`define CTRL_GAIN_LSB 6
`define CTRL_GAIN_MSB 7

// mux register fields
`define MUX_POS_LSB 0
`define MUX_POS_MSB 3
`define MUX_NEG_LSB 4
`define MUX_NEG_MSB 7

// status and mask fields
`define ST_DONE_BIT 0
`define ST_WIN_BIT 1
`define ST_BUSY_BIT 2

// reset values
`define CTRL_RESET 8'h40
`define MUX_RESET 8'h00
`define WIN_LOW_RESET 8'h00
`define WIN_HIGH_RESET 8'hFF
`define MASK_RESET 2'h0

// timing
`define PCLK_MHZ 50
`define RATE_KSPS 500
`define CONV_CYCLES ((`PCLK_MHZ * 1000) / `RATE_KSPS)
`define CONV_SLOTS 10
`define TRACK_SLOTS 2
`define SLOT_CYCLES (`CONV_CYCLES / `CONV_SLOTS)

`endif

//--- sar_adc_pkg.sv
package sar_adc_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TRACK,
      ST_CONVERT
   } conv_state_t;

   typedef enum logic [2:0] {
      TRIG_SOFTWARE,
      TRIG_TIMER0,
      TRIG_TIMER1,
      TRIG_TIMER2,
      TRIG_EXTERNAL
   } trig_sel_t;

   typedef struct packed {
      logic power_on;
      logic track;
      logic [1:0] gain;
      logic [3:0] pos_sel;
      logic [3:0] neg_sel;
      logic [7:0] dac_code;
   } analog_ctrl_t;

endpackage : sar_adc_pkg

//--- slot_divider.sv
`timescale 1ns/10ps
module slot_divider
   #(parameter int DIV = 10)
   (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic clear,
   // enable pulse
   output logic tick
   );

   logic [7:0] count;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count <= 8'h00;
      else if (clear || count == 8'(DIV - 1))
         count <= 8'h00;
      else
         count <= count + 8'h01;
   end

   assign tick = !clear && count == 8'(DIV - 1);

endmodule : slot_divider

//--- trigger_select.sv
`timescale 1ns/10ps
module trigger_select
   import sar_adc_pkg::*;
   (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // sources
   input wire trig_sel_t sel,
   input wire logic sw_start,
   input wire logic [2:0] timer_ovf,
   input wire logic ext_start_pin,
   // request
   output logic start_req
   );

   logic [2:0] ext_sync;
   logic ext_level;
   logic ext_rise;

   // pin crosses into pclk; a level counts once the last two stages agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ext_sync <= 3'h0;
      else
         ext_sync <= {ext_sync[1:0], ext_start_pin};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ext_level <= 1'b0;
      else if (ext_sync[1] == ext_sync[2])
         ext_level <= ext_sync[2];
   end

   assign ext_rise = ext_sync[1] && ext_sync[2] && !ext_level;

   always_comb
   begin
      case (sel)
         TRIG_SOFTWARE: start_req = sw_start;
         TRIG_TIMER0: start_req = timer_ovf[0];
         TRIG_TIMER1: start_req = timer_ovf[1];
         TRIG_TIMER2: start_req = timer_ovf[2];
         TRIG_EXTERNAL: start_req = ext_rise;
         default: start_req = 1'b0;
      endcase
   end

endmodule : trigger_select

//--- sar_adc_ctrl.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "sar_adc_consts.svh"
// What this block does
// - start on software, timer 0/1/2 overflow or external pin, as selected
// - on completion set done flag; interrupt only if its mask bit enables it
// - latch each 8-bit result, held until the next conversion completes
// - window flag set only when result is inside, or outside, the limits
// - software picks positive and negative inputs independently
// - software gain field picks one half, one, two or four
// - enable bit shuts the converter down; no conversion starts while off, but one can still complete in the first cycle off
// - conversions run back to back at up to 500 ksps
module sar_adc_ctrl
   import sar_adc_pkg::*;
   (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // triggers
   input wire logic [2:0] timer_ovf,
   input wire logic ext_start_pin,
   // analog macro
   input wire logic cmp_in,
   output analog_ctrl_t ana,
   // interrupt
   output logic irq
   );

   localparam int CONV_LEN = `CONV_CYCLES;

   logic [7:0] ctrl;
   logic [7:0] mux;
   logic [7:0] win_low;
   logic [7:0] win_high;
   logic [7:0] result;
   logic [1:0] status;
   logic [1:0] mask;
   conv_state_t state;
   logic [2:0] bit_idx;
   logic [1:0] track_cnt;
   logic [7:0] trial;
   logic [7:0] decided;
   logic [7:0] conv_len;
   logic tick;
   logic start_req;
   logic start_go;
   logic conv_done;
   logic busy;
   logic in_range;
   logic win_hit;
   logic wr_en;
   logic rd_setup;
   logic addr_ok;
   logic sw_start;
   logic [1:0] clear_w1c;

   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign addr_ok = paddr == `OFS_CTRL || paddr == `OFS_MUX || paddr == `OFS_RESULT
      || paddr == `OFS_WIN_LOW || paddr == `OFS_WIN_HIGH || paddr == `OFS_STATUS
      || paddr == `OFS_MASK;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign sw_start = wr_en && paddr == `OFS_CTRL && pwdata[`CTRL_SWSTART_BIT];
   assign clear_w1c = (wr_en && paddr == `OFS_STATUS) ? pwdata[1:0] : 2'h0;
   assign busy = state != ST_IDLE;

   // control; the start bit is a strobe and never stored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= `CTRL_RESET;
      else if (wr_en && paddr == `OFS_CTRL)
         ctrl <= pwdata[7:0] & ~(8'h01 << `CTRL_SWSTART_BIT);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mux <= `MUX_RESET;
      else if (wr_en && paddr == `OFS_MUX)
         mux <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         win_low <= `WIN_LOW_RESET;
         win_high <= `WIN_HIGH_RESET;
      end
      else if (wr_en && paddr == `OFS_WIN_LOW)
         win_low <= pwdata[7:0];
      else if (wr_en && paddr == `OFS_WIN_HIGH)
         win_high <= pwdata[7:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask <= `MASK_RESET;
      else if (wr_en && paddr == `OFS_MASK)
         mask <= pwdata[1:0];
   end

   // read data registered in the setup cycle so pready can stay high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
      begin
         if (paddr == `OFS_CTRL)
            prdata <= {24'h00_0000, ctrl};
         else if (paddr == `OFS_MUX)
            prdata <= {24'h00_0000, mux};
         else if (paddr == `OFS_RESULT)
            prdata <= {24'h00_0000, result};
         else if (paddr == `OFS_WIN_LOW)
            prdata <= {24'h00_0000, win_low};
         else if (paddr == `OFS_WIN_HIGH)
            prdata <= {24'h00_0000, win_high};
         else if (paddr == `OFS_STATUS)
            prdata <= {29'h0000_0000, busy, status};
         else if (paddr == `OFS_MASK)
            prdata <= {30'h0000_0000, mask};
         else
            prdata <= 32'h0000_0000;
      end
   end

   trigger_select u_trig (
      .pclk(pclk),
      .presetn(presetn),
      .sel(trig_sel_t'(ctrl[`CTRL_TRIG_MSB:`CTRL_TRIG_LSB])),
      .sw_start(sw_start),
      .timer_ovf(timer_ovf),
      .ext_start_pin(ext_start_pin),
      .start_req(start_req)
   );

   // starts while busy or shut down are dropped, not queued; the completing
   // cycle already takes the next one, so a 100-cycle sample period holds
   assign start_go = start_req && (!busy || conv_done) && ctrl[`CTRL_EN_BIT];

   // held at zero while idle; wraps on its own for a back-to-back start
   slot_divider #(.DIV(`SLOT_CYCLES)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .clear(!busy),
      .tick(tick)
   );

   assign decided = cmp_in ? trial : (trial & ~(8'h01 << bit_idx));
   assign conv_done = state == ST_CONVERT && tick && bit_idx == 3'h0;

   // sequencer: two track slots then eight bit trials, one slot each
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         bit_idx <= 3'h7;
         track_cnt <= 2'h0;
         trial <= 8'h00;
      end
      else if (!ctrl[`CTRL_EN_BIT])
         state <= ST_IDLE;
      else
      begin
         case (state)
            ST_IDLE:
               if (start_go)
               begin
                  state <= ST_TRACK;
                  track_cnt <= 2'h0;
               end
            ST_TRACK:
               if (tick)
               begin
                  if (track_cnt == 2'(`TRACK_SLOTS - 1))
                  begin
                     state <= ST_CONVERT;
                     bit_idx <= 3'h7;
                     trial <= 8'h80;
                  end
                  else
                     track_cnt <= track_cnt + 2'h1;
               end
            ST_CONVERT:
               if (tick)
               begin
                  if (bit_idx == 3'h0)
                  begin
                     state <= start_go ? ST_TRACK : ST_IDLE;
                     track_cnt <= 2'h0;
                  end
                  else
                  begin
                     trial <= decided | (8'h01 << (bit_idx - 3'h1));
                     bit_idx <= bit_idx - 3'h1;
                  end
               end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         result <= 8'h00;
      else if (conv_done)
         result <= decided;
   end

   assign in_range = decided >= win_low && decided <= win_high;
   assign win_hit = ctrl[`CTRL_WINOUT_BIT] ? !in_range : in_range;

   // a completion in the same cycle as a clear keeps the flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status <= 2'h0;
      else
      begin
         status[`ST_DONE_BIT] <= (status[`ST_DONE_BIT] && !clear_w1c[`ST_DONE_BIT]) || conv_done;
         status[`ST_WIN_BIT] <= (status[`ST_WIN_BIT] && !clear_w1c[`ST_WIN_BIT]) || (conv_done && win_hit);
      end
   end

   assign irq = |(status & mask);

   always_comb
   begin
      ana.power_on = ctrl[`CTRL_EN_BIT];
      ana.track = state == ST_TRACK;
      ana.gain = ctrl[`CTRL_GAIN_MSB:`CTRL_GAIN_LSB];
      ana.pos_sel = mux[`MUX_POS_MSB:`MUX_POS_LSB];
      ana.neg_sel = mux[`MUX_NEG_MSB:`MUX_NEG_LSB];
      ana.dac_code = (state == ST_CONVERT) ? trial : 8'h00;
   end

   // helper: cycles since the accepted start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         conv_len <= 8'h00;
      else if (start_go)
         conv_len <= 8'h00;
      else if (busy)
         conv_len <= conv_len + 8'h01;
   end

   AST_START_TRACK: assert property (@(posedge pclk) disable iff (!presetn)
      start_go |=> state == ST_TRACK)
      else $error("accepted trigger did not start tracking");

   AST_DONE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      conv_done |=> status[`ST_DONE_BIT] && (irq == (mask[`ST_DONE_BIT] || (status[`ST_WIN_BIT] && mask[`ST_WIN_BIT]))))
      else $error("done flag or its interrupt wrong after completion");

   AST_RESULT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      !conv_done |=> $stable(result))
      else $error("result changed without a completion");

   AST_WIN_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      !status[`ST_WIN_BIT] && !(conv_done && win_hit) |=> !status[`ST_WIN_BIT])
      else $error("window flag set without a window hit");

   AST_MUX_SEL: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `OFS_MUX |=> ana.pos_sel == $past(pwdata[3:0]) && ana.neg_sel == $past(pwdata[7:4]))
      else $error("input selects do not follow the written value");

   AST_GAIN_SEL: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `OFS_CTRL |=> ana.gain == $past(pwdata[7:6]))
      else $error("gain does not follow the written value");

   AST_SHUTDOWN: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl[`CTRL_EN_BIT] |=> !busy ##1 !conv_done)
      else $error("converter active while shut down");

   AST_CONV_LEN: assert property (@(posedge pclk) disable iff (!presetn)
      conv_done |-> conv_len == 8'(CONV_LEN - 1))
      else $error("conversion length differs from the sample period");

   AST_IGNORE_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
      busy && start_req && !conv_done && ctrl[`CTRL_EN_BIT] |=> conv_len == $past(conv_len) + 8'h01)
      else $error("trigger restarted a running conversion");

   AST_DONE_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
      status[`ST_DONE_BIT] && !clear_w1c[`ST_DONE_BIT] |=> status[`ST_DONE_BIT])
      else $error("done flag dropped without a software clear");

endmodule : sar_adc_ctrl

//--- analog_front_model.sv
`timescale 1ns/10ps
module analog_front_model
   import sar_adc_pkg::*;
   (
   // clock
   input wire logic pclk,
   // analog side
   input wire analog_ctrl_t ana,
   input wire logic [7:0] base,
   output logic cmp_in
   );
   logic flip = 1'b0;
   // channel p sits at base ^ 17*p, negative input n at 4*n, gain after the difference
   function automatic int level(input logic [7:0] b, input logic [3:0] p, input logic [3:0] n,
      input logic [1:0] g);
      int d;
      d = int'(b ^ (8'(p) * 8'h11)) - 4 * int'(n);
      d = (g == 2'h0) ? d / 2 : d * (1 << (g - 1));
      return (d < 0) ? 0 : ((d > 255) ? 255 : d);
   endfunction : level
   always @(posedge pclk)
      flip <= ~flip;
   // outside a trial the output means nothing, so it wanders
   assign cmp_in = (ana.power_on && !ana.track && ana.dac_code != 8'h00) ?
      (level(base, ana.pos_sel, ana.neg_sel, ana.gain) >= int'(ana.dac_code)) : flip;
endmodule : analog_front_model

//--- tb_top.sv
`timescale 1ns/10ps
`include "sar_adc_consts.svh"
module tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_start_pin = 1'b0;
   logic [7:0] paddr = 8'h00, base = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0] timer_ovf = 3'h0;
   logic pready, pslverr, err, irq, cmp_in;
   sar_adc_pkg::analog_ctrl_t ana;
   int n_errors = 0, checks = 0, n_conv = 0;
   int seed = 32'h9CFA;
   logic [7:0] reg_ofs [7] = '{`OFS_CTRL, `OFS_MUX, `OFS_RESULT, `OFS_WIN_LOW, `OFS_WIN_HIGH, `OFS_STATUS, `OFS_MASK};
   logic [31:0] reg_rst [7] = '{`CTRL_RESET, `MUX_RESET, 32'h0, `WIN_LOW_RESET, `WIN_HIGH_RESET, 32'h0, `MASK_RESET};

   always #10 pclk = ~pclk;
   // each conversion opens with a track phase
   always @(posedge ana.track)
      n_conv++;

   sar_adc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_ovf(timer_ovf), .ext_start_pin(ext_start_pin), .cmp_in(cmp_in), .ana(ana), .irq(irq));
   analog_front_model afe (.pclk(pclk), .ana(ana), .base(base), .cmp_in(cmp_in));

   task automatic report_and_stop();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic guard(input logic ok);
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("ERROR %0t wait ran out", $time);
         report_and_stop();
      end
   endtask : guard

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      guard(n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wait_done();
      int n;
      n = 0;
      do
      begin
         apb(1'b0, `OFS_STATUS, 32'h0);
         n++;
      end
      while (rd[0] !== 1'b1 && n < 100);
      guard(rd[0]);
   endtask : wait_done

   task automatic pulse(input logic [2:0] m);
      timer_ovf <= m;
      @(posedge pclk);
      timer_ovf <= 3'h0;
      @(posedge pclk);
   endtask : pulse

   initial
   begin
      int c0, lo, hi, r, pos, neg, g, m, w, cfg;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (reg_ofs[i])
      begin
         apb(1'b0, reg_ofs[i], 32'h0);
         chk(rd, reg_rst[i], "reset value");
         chk(err, 1'b0, "mapped error");
      end
      apb(1'b0, 8'h1C, 32'h0);
      chk(rd, 32'h0, "unmapped data");
      chk(err, 1'b1, "unmapped error");
      apb(1'b1, `OFS_RESULT, 32'hAA);
      apb(1'b0, `OFS_RESULT, 32'h0);
      chk(rd, 32'h0, "result written");
      for (int i = 0; i < 12; i++)
      begin
         base <= 8'($random(seed));
         pos = $unsigned($random(seed)) % 10;
         neg = $unsigned($random(seed)) % 10;
         lo = $unsigned($random(seed)) % 128;
         hi = lo + $unsigned($random(seed)) % 128;
         g = i % 4;
         m = (i + 1) % 4;
         cfg = g * 64 + (i / 4 % 2) * 32 + 1;
         apb(1'b1, `OFS_WIN_LOW, lo);
         apb(1'b1, `OFS_WIN_HIGH, hi);
         apb(1'b1, `OFS_MASK, m);
         apb(1'b1, `OFS_MUX, neg * 16 + pos);
         apb(1'b1, `OFS_CTRL, cfg);
         chk(ana.gain, g, "gain");
         chk({ana.neg_sel, ana.pos_sel}, neg * 16 + pos, "input pair");
         apb(1'b1, `OFS_CTRL, cfg + 2);
         wait_done();
         r = afe.level(base, pos, neg, g);
         w = ((r >= lo && r <= hi) ? 1 : 0) ^ (i / 4 % 2);
         chk(rd[1:0], w * 2 + 1, "status flags");
         apb(1'b0, `OFS_RESULT, 32'h0);
         chk(rd, r, "result");
         chk(irq, (m & (w * 2 + 1)) != 0, "irq level");
         apb(1'b1, `OFS_STATUS, 32'h3);
         chk(irq, 1'b0, "irq after clear");
      end
      apb(1'b1, `OFS_MASK, 32'h0);
      // codes 5 to 7 select nothing, so no source starts a conversion at them
      for (int t = 1; t < 8; t++)
      begin
         c0 = n_conv;
         apb(1'b1, `OFS_CTRL, 32'h41 + t * 4);
         apb(1'b1, `OFS_CTRL, 32'h43 + t * 4);
         pulse(3'h7 & ~(3'h1 << (t - 1)));
         ext_start_pin <= t > 4;
         repeat (8) @(posedge pclk);
         chk(n_conv, c0, "unselected source");
         if (t < 4)
            pulse(3'h1 << (t - 1));
         else if (t == 4)
            ext_start_pin <= 1'b1;
         if (t < 5)
         begin
            wait_done();
            chk(n_conv, c0 + 1, "selected source");
            apb(1'b1, `OFS_STATUS, 32'h1);
         end
         ext_start_pin <= 1'b0;
      end
      // clearing the enable mid-conversion must abort it
      c0 = n_conv;
      apb(1'b1, `OFS_CTRL, 32'h41);
      apb(1'b1, `OFS_CTRL, 32'h43);
      apb(1'b1, `OFS_CTRL, 32'h40);
      chk(ana.power_on, 1'b0, "powered down");
      repeat (110) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(rd[2:0], 3'h0, "aborted conversion");
      chk(n_conv, c0 + 1, "abort started");
      apb(1'b1, `OFS_CTRL, 32'h42);
      pulse(3'h7);
      repeat (8) @(posedge pclk);
      chk(n_conv, c0 + 1, "start while off");
      apb(1'b1, `OFS_CTRL, 32'h45);
      c0 = n_conv;
      pulse(3'h1);
      repeat (48) @(posedge pclk);
      pulse(3'h1);
      repeat (2) @(posedge pclk);
      chk(n_conv, c0 + 1, "start while busy");
      // next trigger lands in the completing cycle: a 100-cycle period
      repeat (46) @(posedge pclk);
      pulse(3'h1);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk(rd[0], 1'b1, "first done in time");
      chk(n_conv, c0 + 2, "back to back start");
      apb(1'b1, `OFS_STATUS, 32'h1);
      wait_done();
      apb(1'b0, `OFS_RESULT, 32'h0);
      chk(rd, afe.level(base, pos, neg, 1), "second result");
      report_and_stop();
   end
endmodule : tb_top
